// File: pkg/trb_pkg.sv
/*
  Shared constants and types of the timer resources block: register
  indices, field layouts, reset values and timing counts.
  Assumes a 20 MHz oscillator clock from which the instruction clock
  (oscillator / 4) is made inside the block.
*/
`default_nettype none

package trb_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned FOSC_HZ     = 20_000_000;
  localparam int unsigned INSTR_DIV   = 4;
  localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);
  localparam int unsigned PRESC_WIDTH = 8;

  // ---------------------------------------------------------------
  // bus decode: byte address = 4 * register index
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_LSB      = 2;
  localparam int unsigned ADDR_IDX_MSB  = 9;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [7:0]  IDX_NONE      = 8'hff;
  localparam logic [7:0]  IDX_MAIN_CTRL = 8'h05;
  localparam logic [7:0]  IDX_MAIN_LO   = 8'h0b;
  localparam logic [7:0]  IDX_MAIN_HI   = 8'h0c;
  localparam logic [7:0]  IDX_IRQ       = 8'h20;
  localparam logic [7:0]  IDX_TCTL      = 8'h21;
  localparam logic [7:0]  IDX_FIRST     = 8'h22;
  localparam logic [7:0]  IDX_SECOND    = 8'h23;
  localparam logic [7:0]  IDX_FIRST_PR  = 8'h24;
  localparam logic [7:0]  IDX_SECOND_PR = 8'h25;
  localparam logic [7:0]  IDX_WIDE_LO   = 8'h26;
  localparam logic [7:0]  IDX_WIDE_HI   = 8'h27;
  localparam logic [7:0]  IDX_WIDE_PR_LO = 8'h28;
  localparam logic [7:0]  IDX_WIDE_PR_HI = 8'h29;

  // ---------------------------------------------------------------
  // flags: status in low bits, enables from ENABLE_LSB
  // ---------------------------------------------------------------
  localparam int unsigned NUM_FLAGS   = 4;
  localparam int unsigned FLAG_MAIN   = 0;
  localparam int unsigned FLAG_FIRST  = 1;
  localparam int unsigned FLAG_SECOND = 2;
  localparam int unsigned FLAG_WIDE   = 3;
  localparam int unsigned ENABLE_LSB  = 8;

  // ---------------------------------------------------------------
  // register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       ext_int_edge;
    logic       count_edge_select;
    logic       count_source_select;
    logic [3:0] prescale_code;
    logic       unused0;
  } trb_main_ctrl_t;

  typedef struct packed {
    logic four_capture;
    logic join16;
    logic wide_ext;
    logic second_ext;
    logic first_ext;
    logic wide_on;
    logic second_on;
    logic first_on;
  } trb_tctl_t;

  localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] TCTL_RESET      = 8'h00;
  localparam int unsigned PS_DIV256_BIT  = 3;

endpackage

`default_nettype wire

// File: hdl/trb_prescaler.sv
/*
  Programmable prescaler of the main counter with its synchroniser.
  Assumes the source level is already a clean level sampled on mclk_in.
*/
`timescale 1ns/10ps
`default_nettype none

module trb_prescaler #(
  parameter int unsigned WIDTH = trb_pkg::PRESC_WIDTH
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       src_level_in,
  input  wire logic [3:0] code_in,
  input  wire logic       clear_in,
  output logic            tick_out
);

  logic             src_prev_q;
  logic             primed_q;
  logic [WIDTH-1:0] cnt_q;
  logic             psout;
  logic             sync1_q;
  logic             sync2_q;
  logic             sync3_q;

  // ---------------------------------------------------------------
  // divider on rising source edges
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_prev_q <= 1'b0;
      cnt_q      <= '0;
      primed_q   <= 1'b0;
    end else if (ce_in) begin
      src_prev_q <= src_level_in;
      primed_q   <= 1'b1;
      if (clear_in) begin
        cnt_q <= '0;
      end else if (primed_q && src_level_in && !src_prev_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    if (code_in[trb_pkg::PS_DIV256_BIT]) begin
      psout = cnt_q[WIDTH-1];
    end else if (code_in == 4'h0) begin
      psout = src_level_in;
    end else begin
      psout = cnt_q[3'(code_in[2:0] - 3'h1)];
    end
  end

  // ---------------------------------------------------------------
  // synchronise after the divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce_in) begin
      // first cycle loads the idle level: no false edge after reset
      sync1_q <= psout;
      sync2_q <= primed_q ? sync1_q : psout;
      sync3_q <= primed_q ? sync2_q : psout;
    end
  end

  assign tick_out = sync2_q && !sync3_q;

endmodule // trb_prescaler

`default_nettype wire

// File: hdl/trb_timers.sv
/*
  Timer resources: main 16-bit counter with prescaler, two 8-bit period
  timers that may be joined, and a 16-bit period/capture timer, all
  reached over an AHB-Lite slave port.
  Assumes count pins and capture strobe are synchronous to mclk_in,
  which is the oscillator clock; one clock enable freezes everything.
*/
// The implementer's own choice: the AHB-Lite register port.
// Overview of operation
// - main counter is 16 bits, high and low byte, behind 8-bit prescaler
// - source bit 1 counts instruction clock, 0 counts the main count pin
// - edge bit picks rising (1) or falling (0) pin edge, external only
// - prescale code 0..7 divides by 1..128 doubling, 1xxx by 256
// - external count pin is synchronised after the prescaler
// - first timer wraps at its period to zero and sets its flag
// - first and second timers may count the shared count pin
// - joined mode forms 16-bit timer, flag on first timer's flag
// - second timer wraps at its period to zero and sets its flag
// - wide timer is 16 bits, wraps to zero and sets its flag
// - wide timer counts its own dedicated count pin in counter mode
// - four-capture mode turns wide period register into a capture
// - byte timers and wide timer drive the time base outputs
// - main counter wraps FFFFh to 0000h, sets flag, cleared on vector
// - byte write clears prescaler, holds that byte one cycle
`timescale 1ns/10ps
`default_nettype none

module trb_timers (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  input  wire logic        main_count_pin_in,
  input  wire logic        shared_count_pin_in,
  input  wire logic        wide_count_pin_in,
  input  wire logic        wide_capture_in,
  input  wire logic        main_vector_ack_in,
  output logic [3:0]       irq_out,
  output logic [7:0]       first_time_base_out,
  output logic [7:0]       second_time_base_out,
  output logic [15:0]      wide_time_base_out
);

  trb_pkg::trb_main_ctrl_t ctrl_q;
  trb_pkg::trb_tctl_t      tctl_q;
  logic [1:0]  phase_q;
  logic        instr_tick;
  logic        take;
  logic [7:0]  sel_idx;
  logic        wr_q;
  logic [7:0]  wr_idx_q;
  logic        rd_q;
  logic [7:0]  rd_idx_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata;
  logic [7:0]  wbyte;
  logic        wr_ctrl;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_irq;
  logic        wr_tctl;
  logic        wr_t1;
  logic        wr_t2;
  logic        wr_pr1;
  logic        wr_pr2;
  logic        wr_t3l;
  logic        wr_t3h;
  logic        wr_pr3l;
  logic        wr_pr3h;
  logic [7:0]  main_lo_q;
  logic [7:0]  main_hi_q;
  logic        inh_lo_q;
  logic        inh_hi_q;
  logic        main_src;
  logic        main_tick;
  logic        lo_inc;
  logic        hi_inc;
  logic        main_ovf;
  logic        shared_prev_q;
  logic        wide_prev_q;
  logic        shared_fall;
  logic        wide_fall;
  logic [7:0]  t1_q;
  logic [7:0]  t2_q;
  logic [7:0]  pr1_q;
  logic [7:0]  pr2_q;
  logic [15:0] t3_q;
  logic [15:0] pr3_q;
  logic        t1_tick;
  logic        t2_tick;
  logic        t3_tick;
  logic        match16;
  logic        t3_wrap;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [3:0]  flag_q;
  logic [3:0]  en_q;
  logic [3:0]  irq_q;

  // ---------------------------------------------------------------
  // instruction clock: one tick per four oscillator cycles
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= 2'h0;
    end else if (ce_in) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign instr_tick = (phase_q == trb_pkg::INSTR_LAST);

  // ---------------------------------------------------------------
  // bus slave: writes zero wait, reads one wait state
  // ---------------------------------------------------------------
  assign take    = hsel_in && htrans_in[1] && hready_in;
  assign sel_idx = (|haddr_in[31:trb_pkg::ADDR_IDX_MSB+1]) ?
                   trb_pkg::IDX_NONE :
                   haddr_in[trb_pkg::ADDR_IDX_MSB:trb_pkg::ADDR_LSB];

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q     <= 1'b0;
      wr_idx_q <= 8'h00;
      rd_q     <= 1'b0;
      rd_idx_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      wr_q     <= take && hwrite_in && (hsize_in == trb_pkg::HSIZE_WORD);
      wr_idx_q <= sel_idx;
      rd_q     <= take && !hwrite_in;
      if (take) begin
        rd_idx_q <= sel_idx;
      end
      hready_q <= !(take && !hwrite_in);
      if (rd_q) begin
        hrdata_q <= rdata;
      end
    end
  end

  assign wbyte   = hwdata_in[7:0];
  assign wr_ctrl = wr_q && (wr_idx_q == trb_pkg::IDX_MAIN_CTRL);
  assign wr_lo   = wr_q && (wr_idx_q == trb_pkg::IDX_MAIN_LO);
  assign wr_hi   = wr_q && (wr_idx_q == trb_pkg::IDX_MAIN_HI);
  assign wr_irq  = wr_q && (wr_idx_q == trb_pkg::IDX_IRQ);
  assign wr_tctl = wr_q && (wr_idx_q == trb_pkg::IDX_TCTL);
  assign wr_t1   = wr_q && (wr_idx_q == trb_pkg::IDX_FIRST);
  assign wr_t2   = wr_q && (wr_idx_q == trb_pkg::IDX_SECOND);
  assign wr_pr1  = wr_q && (wr_idx_q == trb_pkg::IDX_FIRST_PR);
  assign wr_pr2  = wr_q && (wr_idx_q == trb_pkg::IDX_SECOND_PR);
  assign wr_t3l  = wr_q && (wr_idx_q == trb_pkg::IDX_WIDE_LO);
  assign wr_t3h  = wr_q && (wr_idx_q == trb_pkg::IDX_WIDE_HI);
  assign wr_pr3l = wr_q && (wr_idx_q == trb_pkg::IDX_WIDE_PR_LO);
  assign wr_pr3h = wr_q && (wr_idx_q == trb_pkg::IDX_WIDE_PR_HI);

  always_comb begin
    rdata = 32'h0000_0000;
    case (rd_idx_q)
      trb_pkg::IDX_MAIN_CTRL:  rdata[7:0]  = ctrl_q;
      trb_pkg::IDX_MAIN_LO:    rdata[7:0]  = main_lo_q;
      trb_pkg::IDX_MAIN_HI:    rdata[7:0]  = main_hi_q;
      trb_pkg::IDX_IRQ:        rdata[11:0] = {en_q, 4'h0, flag_q};
      trb_pkg::IDX_TCTL:       rdata[7:0]  = tctl_q;
      trb_pkg::IDX_FIRST:      rdata[7:0]  = t1_q;
      trb_pkg::IDX_SECOND:     rdata[7:0]  = t2_q;
      trb_pkg::IDX_FIRST_PR:   rdata[7:0]  = pr1_q;
      trb_pkg::IDX_SECOND_PR:  rdata[7:0]  = pr2_q;
      trb_pkg::IDX_WIDE_LO:    rdata[7:0]  = t3_q[7:0];
      trb_pkg::IDX_WIDE_HI:    rdata[7:0]  = t3_q[15:8];
      trb_pkg::IDX_WIDE_PR_LO: rdata[7:0]  = pr3_q[7:0];
      trb_pkg::IDX_WIDE_PR_HI: rdata[7:0]  = pr3_q[15:8];
      default:                 rdata       = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= trb_pkg::MAIN_CTRL_RESET;
    end else if (ce_in && wr_ctrl) begin
      ctrl_q <= {wbyte[7:1], 1'b0};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tctl_q <= trb_pkg::TCTL_RESET;
    end else if (ce_in && wr_tctl) begin
      tctl_q <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // main counter
  // ---------------------------------------------------------------
  always_comb begin
    if (ctrl_q.count_source_select) begin
      main_src = phase_q[1];
    end else if (ctrl_q.count_edge_select) begin
      main_src = main_count_pin_in;
    end else begin
      main_src = !main_count_pin_in;
    end
  end

  trb_prescaler #(
    .WIDTH (trb_pkg::PRESC_WIDTH)
  ) u_presc (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .src_level_in (main_src),
    .code_in      (ctrl_q.prescale_code),
    .clear_in     (wr_lo || wr_hi),
    .tick_out     (main_tick)
  );

  assign lo_inc   = main_tick && !inh_lo_q && !wr_lo;
  assign hi_inc   = lo_inc && (main_lo_q == 8'hff) && !inh_hi_q && !wr_hi;
  assign main_ovf = hi_inc && (main_hi_q == 8'hff);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      main_lo_q <= 8'h00;
      main_hi_q <= 8'h00;
      inh_lo_q  <= 1'b0;
      inh_hi_q  <= 1'b0;
    end else if (ce_in) begin
      inh_lo_q <= wr_lo;
      inh_hi_q <= wr_hi;
      if (wr_lo) begin
        main_lo_q <= wbyte;
      end else if (lo_inc) begin
        main_lo_q <= main_lo_q + 8'h01;
      end
      if (wr_hi) begin
        main_hi_q <= wbyte;
      end else if (hi_inc) begin
        main_hi_q <= main_hi_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // byte timers, optionally joined
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shared_prev_q <= 1'b0;
      wide_prev_q   <= 1'b0;
    end else if (ce_in) begin
      shared_prev_q <= shared_count_pin_in;
      wide_prev_q   <= wide_count_pin_in;
    end
  end

  assign shared_fall = shared_prev_q && !shared_count_pin_in;
  assign wide_fall   = wide_prev_q && !wide_count_pin_in;
  assign t1_tick = tctl_q.first_on &&
                   (tctl_q.first_ext ? shared_fall : instr_tick);
  assign t2_tick = tctl_q.second_on && !tctl_q.join16 &&
                   (tctl_q.second_ext ? shared_fall : instr_tick);
  assign match16 = ({t2_q, t1_q} == {pr2_q, pr1_q});

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t1_q  <= 8'h00;
      t2_q  <= 8'h00;
      pr1_q <= 8'h00;
      pr2_q <= 8'h00;
    end else if (ce_in) begin
      if (wr_pr1) begin
        pr1_q <= wbyte;
      end
      if (wr_pr2) begin
        pr2_q <= wbyte;
      end
      if (wr_t1) begin
        t1_q <= wbyte;
      end else if (t1_tick) begin
        if (tctl_q.join16 ? match16 : (t1_q == pr1_q)) begin
          t1_q <= 8'h00;
        end else begin
          t1_q <= t1_q + 8'h01;
        end
      end
      if (wr_t2) begin
        t2_q <= wbyte;
      end else if (tctl_q.join16 && t1_tick && !wr_t1) begin
        if (match16) begin
          t2_q <= 8'h00;
        end else if (t1_q == 8'hff) begin
          t2_q <= t2_q + 8'h01;
        end
      end else if (t2_tick) begin
        t2_q <= (t2_q == pr2_q) ? 8'h00 : t2_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // wide timer with period or capture register
  // ---------------------------------------------------------------
  assign t3_tick = tctl_q.wide_on &&
                   (tctl_q.wide_ext ? wide_fall : instr_tick);
  assign t3_wrap = (t3_q == 16'hffff) ||
                   (!tctl_q.four_capture && (t3_q == pr3_q));

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t3_q  <= 16'h0000;
      pr3_q <= 16'h0000;
    end else if (ce_in) begin
      if (tctl_q.four_capture && wide_capture_in) begin
        pr3_q <= t3_q;
      end else begin
        if (wr_pr3l) begin
          pr3_q[7:0] <= wbyte;
        end
        if (wr_pr3h) begin
          pr3_q[15:8] <= wbyte;
        end
      end
      if (wr_t3l || wr_t3h) begin
        if (wr_t3l) begin
          t3_q[7:0] <= wbyte;
        end
        if (wr_t3h) begin
          t3_q[15:8] <= wbyte;
        end
      end else if (t3_tick) begin
        t3_q <= t3_wrap ? 16'h0000 : t3_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over a write-one clear or a vector clear
  // ---------------------------------------------------------------
  assign flag_set[trb_pkg::FLAG_MAIN]   = main_ovf;
  assign flag_set[trb_pkg::FLAG_FIRST]  = t1_tick && !wr_t1 &&
         (tctl_q.join16 ? match16 : (t1_q == pr1_q));
  assign flag_set[trb_pkg::FLAG_SECOND] = t2_tick && !wr_t2 &&
         (t2_q == pr2_q);
  assign flag_set[trb_pkg::FLAG_WIDE]   = t3_tick && !wr_t3l && !wr_t3h &&
         t3_wrap;

  generate
    for (genvar i = 0; i < trb_pkg::NUM_FLAGS; i++) begin : g_flag
      assign flag_clr[i] = (wr_irq && hwdata_in[i]) ||
             ((i == trb_pkg::FLAG_MAIN) && main_vector_ack_in);
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          flag_q[i] <= 1'b0;
          en_q[i]   <= 1'b0;
          irq_q[i]  <= 1'b0;
        end else if (ce_in) begin
          flag_q[i] <= flag_set[i] || (flag_q[i] && !flag_clr[i]);
          if (wr_irq) begin
            en_q[i] <= hwdata_in[trb_pkg::ENABLE_LSB + i];
          end
          irq_q[i] <= flag_q[i] && en_q[i];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout_out        = hready_q;
  assign hrdata_out           = hrdata_q;
  assign hresp_out            = trb_pkg::HRESP_OKAY;
  assign irq_out              = irq_q;
  assign first_time_base_out  = t1_q;
  assign second_time_base_out = t2_q;
  assign wide_time_base_out   = t3_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence lo_written_s;
    ce_in && wr_lo;
  endsequence

  sequence lo_held_s;
    ce_in && !wr_lo;
  endsequence

  ctrl_bit0_zero_a: assert property (
    (ce_in && rd_q && rd_idx_q == trb_pkg::IDX_MAIN_CTRL)
    |=> (hrdata_out[0] == 1'b0))
    else $error("control bit 0 read as one");

  main_wrap_a: assert property (
    (ce_in && main_ovf) |=> (main_lo_q == 8'h00 && main_hi_q == 8'h00
                             && flag_q[trb_pkg::FLAG_MAIN]))
    else $error("main counter overflow did not wrap and flag");

  lo_inhibit_a: assert property (
    lo_written_s ##1 lo_held_s |=> (main_lo_q == $past(main_lo_q)))
    else $error("low byte counted in cycle after write");

  first_period_a: assert property (
    (ce_in && t1_tick && !tctl_q.join16 && !wr_t1 && t1_q == pr1_q)
    |=> (t1_q == 8'h00 && flag_q[trb_pkg::FLAG_FIRST]))
    else $error("first timer period rollover wrong");

  second_period_a: assert property (
    (ce_in && t2_tick && !wr_t2 && t2_q == pr2_q)
    |=> (t2_q == 8'h00 && flag_q[trb_pkg::FLAG_SECOND]))
    else $error("second timer period rollover wrong");

  join_wrap_a: assert property (
    (ce_in && tctl_q.join16 && t1_tick && match16 && !wr_t1 && !wr_t2)
    |=> (t1_q == 8'h00 && t2_q == 8'h00 && flag_q[trb_pkg::FLAG_FIRST]))
    else $error("joined timer rollover wrong");

  wide_wrap_a: assert property (
    (ce_in && t3_tick && t3_wrap && !wr_t3l && !wr_t3h)
    |=> (t3_q == 16'h0000 && flag_q[trb_pkg::FLAG_WIDE]))
    else $error("wide timer rollover wrong");

  capture_load_a: assert property (
    (ce_in && tctl_q.four_capture && wide_capture_in)
    |=> (pr3_q == $past(t3_q)))
    else $error("capture did not load wide counter value");

  shared_pin_a: assert property (
    (ce_in && tctl_q.first_on && tctl_q.first_ext && !shared_fall
     && !wr_t1) |=> $stable(t1_q))
    else $error("first timer counted without shared pin edge");

endmodule // trb_timers

`default_nettype wire

// File: bench/trb_pins.sv
/*
  Count-pin partner: drives the three external count pins.
  Assumes tog is called just after a rising edge of mclk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module trb_pins (
  input  wire logic mclk_in,
  output logic      main_pin_out,
  output logic      shared_pin_out,
  output logic      wide_pin_out
);
  initial {main_pin_out, shared_pin_out, wide_pin_out} = 3'h0;
  // n level changes, four clocks apart, on pin sel
  task automatic tog(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk_in);
      case (sel)
        0: main_pin_out <= !main_pin_out;
        1: shared_pin_out <= !shared_pin_out;
        default: wide_pin_out <= !wide_pin_out;
      endcase
    end
  endtask
endmodule // trb_pins
`default_nettype wire

// File: bench/trb_timers_tb.sv
/*
  Self-checking bench of trb_timers: bus master, queued read checks.
  Assumes one slave on the bus and the pin partner trb_pins.
*/
`timescale 1ns/10ps
`default_nettype none
module trb_timers_tb;
  logic        mclk_in = 1'b0, rst_n_in = 1'b0, hsel = 1'b0, ce = 1'b1;
  logic        hwrite = 1'b0, ack = 1'b0, cap = 1'b0, rd_pend = 1'b0;
  logic        hready, hresp, pm, ps, pw;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0]  irq;
  logic [7:0]  tb1, tb2, p8;
  logic [15:0] tbw;
  logic [31:0] q_e[$], q_s[$];
  int          bad_count = 0, num_checks = 0, cyc = 0, dv;
  integer      seed = 32'h7f3162ae;
  always #25 mclk_in = !mclk_in;
  trb_pins u_pins (.mclk_in(mclk_in), .main_pin_out(pm),
    .shared_pin_out(ps), .wide_pin_out(pw));
  trb_timers u_trb_timers (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(trb_pkg::HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hrdata_out(hrdata), .hresp_out(hresp), .main_count_pin_in(pm),
    .shared_count_pin_in(ps), .wide_count_pin_in(pw),
    .wide_capture_in(cap), .main_vector_ack_in(ack), .irq_out(irq),
    .first_time_base_out(tb1), .second_time_base_out(tb2),
    .wide_time_base_out(tbw));
  task automatic chk(input logic [31:0] g, e, s);
    num_checks++;
    if (((g >= e) && (g <= e + s)) !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic [7:0] idx, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, s);
    q_e.push_back(e);
    q_s.push_back(s);
    bus(idx, 1'b0, 32'h0);
  endtask
  task automatic rst();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
  endtask
  task automatic clr();
    wr(trb_pkg::IDX_MAIN_LO, 32'h0);
    wr(trb_pkg::IDX_MAIN_HI, 32'h0);
  endtask
  task automatic trow(input logic [7:0] tc, input logic [15:0] per,
                      input int pin, np, input logic [31:0] etb, efl);
    rst();
    wr(trb_pkg::IDX_FIRST_PR, 32'(per[7:0]));
    wr(trb_pkg::IDX_SECOND_PR, 32'(per[15:8]));
    wr(trb_pkg::IDX_WIDE_PR_LO, 32'(per[7:0]));
    wr(trb_pkg::IDX_WIDE_PR_HI, 32'(per[15:8]));
    wr(trb_pkg::IDX_TCTL, 32'(tc));
    u_pins.tog(pin, 2 * np);
    repeat (4) @(posedge mclk_in);
    chk({tbw, tb2, tb1}, etb, 32'h0);
    rd(trb_pkg::IDX_IRQ, efl, 32'h0);
  endtask
  // read data checked against the oldest queued expectation
  always @(posedge mclk_in) begin
    if (rd_pend && hready) begin
      chk(hrdata, q_e.pop_front(), q_s.pop_front());
      chk(32'(hresp), 32'(trb_pkg::HRESP_OKAY), 32'h0);
    end
    if (hready) rd_pend <= htrans[1] && !hwrite;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    rst();
    rd(trb_pkg::IDX_MAIN_CTRL, 32'h0, 32'h0);
    wr(trb_pkg::IDX_MAIN_CTRL, 32'hffff_ffff);
    rd(trb_pkg::IDX_MAIN_CTRL, 32'hfe, 32'h0);
    rd(8'h3f, 32'h0, 32'h0);
    for (int k = 0; k < 10; k++) begin
      dv = (k > 7) ? 256 : (1 << k);
      wr(trb_pkg::IDX_MAIN_CTRL, {27'h1, (k > 8) ? 4'hf : 4'(k), 1'b0});
      clr();
      repeat (32 * dv) @(posedge mclk_in);
      rd(trb_pkg::IDX_MAIN_LO, 32'h6, 32'h4);
    end
    for (int e = 0; e < 2; e++) begin
      wr(trb_pkg::IDX_MAIN_CTRL, {25'h0, e[0], 6'h0});
      repeat (8) @(posedge mclk_in);
      clr();
      u_pins.tog(0, 9);
      repeat (8) @(posedge mclk_in);
      rd(trb_pkg::IDX_MAIN_LO, 32'h4, 32'h0);
    end
    rst();
    wr(trb_pkg::IDX_MAIN_CTRL, 32'h20);
    wr(trb_pkg::IDX_IRQ, 32'h100);
    wr(trb_pkg::IDX_MAIN_LO, 32'hfc);
    wr(trb_pkg::IDX_MAIN_HI, 32'hff);
    repeat (40) @(posedge mclk_in);
    chk({28'h0, irq}, 32'h1, 32'h0);
    rd(trb_pkg::IDX_MAIN_HI, 32'h0, 32'h0);
    ack <= 1'b1;
    @(posedge mclk_in);
    ack <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd(trb_pkg::IDX_IRQ, 32'h100, 32'h0);
    p8 = 8'(($random(seed) & 7) + 2);
    trow(8'h09, {8'h0, p8}, 1, p8 + 3, 32'h2, 32'h2);
    trow(8'h12, {p8, 8'h0}, 1, p8 + 3, 32'h200, 32'h4);
    trow(8'h49, {8'h1, p8}, 1, p8 + 259, 32'h2, 32'h2);
    trow(8'h24, {8'h0, p8}, 2, p8 + 3, 32'h20000, 32'h8);
    rst();
    wr(trb_pkg::IDX_TCTL, 32'ha4);
    u_pins.tog(2, 10);
    repeat (4) @(posedge mclk_in);
    cap <= 1'b1;
    @(posedge mclk_in);
    cap <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rd(trb_pkg::IDX_WIDE_PR_LO, 32'h5, 32'h0);
    chk(32'(tbw), 32'h5, 32'h0);
    ce <= 1'b0;
    u_pins.tog(2, 4);
    ce <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk(32'(tbw), 32'h5, 32'h0);
    repeat (2) @(posedge mclk_in);
    results();
  end
endmodule // trb_timers_tb
`default_nettype wire
